// ==== level_sync.sv ====
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_ce,
   // Data
   input  wire logic [WIDTH-1:0] i_async,
   input  wire logic [WIDTH-1:0] i_reset_value,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] stage_one;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         stage_one <= '0;
         o_sync    <= '0;
      end else if (i_ce) begin
         stage_one <= i_async;
         o_sync    <= stage_one;
      end
   end

endmodule : level_sync

// ==== power_event_chk.sv ====
// Assertion checker for the power event block
`timescale 1ns/1ps
module power_event_chk (
   // Clock and reset
   input  wire logic       I_REF_CLK,
   input  wire logic       I_RST,
   input  wire logic       I_CE,
   // Register bus
   input  wire logic [7:0] I_SFR_ADDR,
   input  wire logic       I_SFR_WR,
   input  wire logic [7:0] I_SFR_WDATA,
   input  wire logic       I_SFR_RD,
   input  wire logic [7:0] O_SFR_RDATA,
   // Events and outputs
   input  wire logic       I_LINE_SAG,
   input  wire logic       O_POWER_IRQ,
   input  wire logic       O_FIRST_PIN_ENABLE,
   input  wire logic       O_SECOND_PIN_GPIO,
   input  wire logic       O_SECOND_PIN_BACKUP,
   input  wire logic       O_SECOND_PIN_IRQ_ENABLE
);
   logic [7:0] key;
   logic [3:0] cfg;
   logic [7:0] en;
   logic       wr;
   logic       wr_flg;
   assign wr = I_SFR_WR && I_CE;
   assign wr_flg = wr && (I_SFR_ADDR == 8'hf8);
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);
   // Shadow copies of key, pin configuration and enables
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         key <= 8'h00;
         cfg <= 4'h0;
         en  <= 8'h00;
      end else if (wr) begin
         case (I_SFR_ADDR)
            8'hc1: key <= I_SFR_WDATA;
            8'hec: en <= I_SFR_WDATA & 8'haf;
            8'hff: if (key == 8'hea) cfg <= I_SFR_WDATA[3:0];
            default: ;
         endcase
      end
   end
   sequence sag_rise;
      !I_LINE_SAG ##1 I_LINE_SAG ##1 I_LINE_SAG;
   endsequence
   first_pin_a: assert property ($past(I_CE) |-> O_FIRST_PIN_ENABLE == $past(cfg[0]))
      else $error("first pin enable mismatch");
   second_func_a: assert property ($past(I_CE) |->
      O_SECOND_PIN_GPIO == ($past(cfg[2:1]) == 2'h0) && O_SECOND_PIN_BACKUP == ($past(cfg[2:1]) == 2'h1))
      else $error("second pin function mismatch");
   second_irq_a: assert property ($past(I_CE) |->
      O_SECOND_PIN_IRQ_ENABLE == ($past(cfg[3:2]) == 2'h3)) else $error("second pin irq mismatch");
   key_guard_a: assert property (I_SFR_RD && I_CE && I_SFR_ADDR == 8'hff |=>
      O_SFR_RDATA == {4'h0, $past(cfg)}) else $error("pin config readback mismatch");
   rdata_hold_a: assert property (!(I_SFR_RD && I_CE) |=> $stable(O_SFR_RDATA))
      else $error("read data changed without read");
   irq_sag_a: assert property (sag_rise ##0 en[5] |-> ##[1:5] O_POWER_IRQ)
      else $error("enabled sag gave no interrupt");
   irq_gate_a: assert property ($rose(O_POWER_IRQ) && !$past(wr_flg) |-> en != 8'h00)
      else $error("interrupt with no enable");
   irq_sticky_a: assert property (O_POWER_IRQ && !wr_flg && !$past(wr_flg) |=> O_POWER_IRQ)
      else $error("interrupt flag dropped by itself");
endmodule : power_event_chk

bind power_event_ctrl power_event_chk u_chk (
   .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_SFR_ADDR(I_SFR_ADDR),
   .I_SFR_WR(I_SFR_WR), .I_SFR_WDATA(I_SFR_WDATA), .I_SFR_RD(I_SFR_RD),
   .O_SFR_RDATA(O_SFR_RDATA), .I_LINE_SAG(I_LINE_SAG), .O_POWER_IRQ(O_POWER_IRQ),
   .O_FIRST_PIN_ENABLE(O_FIRST_PIN_ENABLE), .O_SECOND_PIN_GPIO(O_SECOND_PIN_GPIO),
   .O_SECOND_PIN_BACKUP(O_SECOND_PIN_BACKUP), .O_SECOND_PIN_IRQ_ENABLE(O_SECOND_PIN_IRQ_ENABLE));

// ==== power_event_ctrl.sv ====
// Power event flags, enables, scratch bytes and protected interrupt pin configuration
`timescale 1ns/1ps
module power_event_ctrl (
   // Clock, reset, enable
   input  wire logic       I_REF_CLK,
   input  wire logic       I_RST,
   input  wire logic       I_CE,
   // Register bus from the core
   input  wire logic [7:0] I_SFR_ADDR,
   input  wire logic       I_SFR_WR,
   input  wire logic [7:0] I_SFR_WDATA,
   input  wire logic       I_SFR_RD,
   output logic      [7:0] O_SFR_RDATA,
   // Asynchronous supply monitor levels
   input  wire logic       I_SOURCE_IS_MAIN,
   input  wire logic       I_LINE_SAG,
   input  wire logic       I_DC_DELTA,
   input  wire logic       I_DC_READY,
   input  wire logic       I_BATTERY_LOW,
   input  wire logic       I_BATTERY_READY,
   input  wire logic       I_DC_INPUT_LOW,
   // Interrupt and pin function outputs
   output logic            O_POWER_IRQ,
   output logic            O_FIRST_PIN_ENABLE,
   output logic            O_SECOND_PIN_GPIO,
   output logic            O_SECOND_PIN_BACKUP,
   output logic            O_SECOND_PIN_IRQ_ENABLE,
   // Configuration outputs to the analog side
   output logic      [7:0] O_POWER_CONTROL,
   output logic      [7:0] O_SWITCHOVER_CONFIG,
   output logic      [7:0] O_PERIPHERAL_CONFIG
);

   // Number of synchronised monitor levels
   localparam int MON_WIDTH = 7;

   // Monitor vector order
   localparam int MON_SOURCE  = 0;
   localparam int MON_SAG     = 1;
   localparam int MON_DC_DIFF = 2;
   localparam int MON_DC_RDY  = 3;
   localparam int MON_BAT_LOW = 4;
   localparam int MON_BAT_RDY = 5;
   localparam int MON_DC_LOW  = 6;

   // Synchronised monitor levels and their edges
   logic [MON_WIDTH-1:0] mon_async;
   logic [MON_WIDTH-1:0] mon_sync;
   logic [MON_WIDTH-1:0] mon_prev;
   wire  [MON_WIDTH-1:0] mon_rise;
   logic                 source_fall;

   // Software visible registers
   logic [7:0] power_control;
   logic [7:0] power_event_enable;
   logic [7:0] peripheral_config;
   logic [7:0] switchover_config;
   logic [7:0] power_event_flags;
   logic [7:0] int_pin_config;
   logic [7:0] write_key_reg;
   logic [7:0] scratch [power_event_pkg::SCRATCH_COUNT];

   // Next-state helpers
   logic [7:0] events_now;
   logic       combined_event;
   logic       key_open;
   logic [7:0] next_flags;
   logic [7:0] read_value;

   // Write strobe aimed at one address
   function automatic logic write_to(input logic [7:0] addr);
      write_to = I_SFR_WR && (I_SFR_ADDR == addr);
   endfunction : write_to

   // True when a two-bit field of the pin configuration holds the given code
   function automatic logic field_is(input logic [7:0] cfg, input int pos,
                                     input logic [1:0] code);
      field_is = (cfg[pos +: 2] == code);
   endfunction : field_is

   assign mon_async = {I_DC_INPUT_LOW, I_BATTERY_READY, I_BATTERY_LOW,
                       I_DC_READY, I_DC_DELTA, I_LINE_SAG, I_SOURCE_IS_MAIN};

   // Every monitor level passes two flops before any logic reads it
   level_sync #(
      .WIDTH(MON_WIDTH)
   ) u_mon_sync (
      .i_clk        (I_REF_CLK),
      .i_rst        (I_RST),
      .i_ce         (I_CE),
      .i_async      (mon_async),
      .i_reset_value('0),
      .o_sync       (mon_sync)
   );

   // Delayed copy for edge detection
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         mon_prev <= '0;
      end else if (I_CE) begin
         mon_prev <= mon_sync;
      end
   end

   // Prime the monitor history so no edge fires on the first samples after reset
   logic primed;
   logic [1:0] prime_count;

   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         prime_count <= 2'h0;
         primed      <= 1'b0;
      end else if (I_CE) begin
         if (prime_count != 2'h3) begin
            prime_count <= prime_count + 2'h1;
         end
         primed <= (prime_count == 2'h3);
      end
   end

   // Rising edges per monitor; quiet until the history is primed
   genvar m;
   generate
      for (m = 0; m < MON_WIDTH; m++) begin : g_edge
         assign mon_rise[m] = primed & mon_sync[m] & ~mon_prev[m];
      end
   endgenerate

   // Source dropping from main supply to battery
   assign source_fall = primed & ~mon_sync[MON_SOURCE] & mon_prev[MON_SOURCE];

   // Hardware event pulses at their flag positions
   always_comb begin
      events_now = 8'h00;
      events_now[power_event_pkg::BIT_SUPPLY_RESTORED] = mon_rise[MON_SOURCE];  // RULE4
      events_now[power_event_pkg::BIT_LINE_SAG]        = mon_rise[MON_SAG];     // RULE6
      events_now[power_event_pkg::BIT_DC_INPUT_ADC]    =
         mon_rise[MON_DC_DIFF] | mon_rise[MON_DC_RDY];                          // RULE7
      events_now[power_event_pkg::BIT_BATTERY_MONITOR] =
         mon_rise[MON_BAT_LOW] | mon_rise[MON_BAT_RDY];                         // RULE8
      events_now[power_event_pkg::BIT_SWITCHOVER]      = source_fall;           // RULE9
      events_now[power_event_pkg::BIT_DC_INPUT_LOW]    = mon_rise[MON_DC_LOW];  // RULE10
   end

   // Only events whose enable is set raise the combined flag
   assign combined_event = |(events_now & power_event_enable &
                             power_event_pkg::EVENT_MASK);                      // RULE13

   // Software write, then hardware sets on top
   always_comb begin
      next_flags = power_event_flags;
      if (write_to(power_event_pkg::ADDR_POWER_EVENT_FLAGS)) begin
         next_flags = I_SFR_WDATA & power_event_pkg::FLAG_WRITE_MASK;           // RULE11
      end
      next_flags = next_flags | events_now;                                     // RULE14
      if (combined_event) begin
         next_flags[power_event_pkg::BIT_COMBINED_IRQ] = 1'b1;                  // RULE5
      end
   end

   // Sticky flags; a clear in the same cycle never hides an event
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         power_event_flags <= power_event_pkg::RESET_FLAGS;
      end else if (I_CE) begin
         power_event_flags <= next_flags;                                       // RULE14
      end
   end

   // Enable register
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         power_event_enable <= power_event_pkg::RESET_ENABLE;
      end else if (I_CE && write_to(power_event_pkg::ADDR_POWER_EVENT_ENABLE)) begin
         power_event_enable <= I_SFR_WDATA & power_event_pkg::ENABLE_WRITE_MASK; // RULE13
      end
   end

   // Key register
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         write_key_reg <= power_event_pkg::RESET_KEY;
      end else if (I_CE && write_to(power_event_pkg::ADDR_WRITE_KEY)) begin
         write_key_reg <= I_SFR_WDATA;                                          // RULE3
      end
   end

   // Key stays open until software writes any value other than the unlock key
   assign key_open = (write_key_reg == power_event_pkg::WRITE_KEY_UNLOCK);     // RULE2

   // Protected pin configuration
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         int_pin_config <= power_event_pkg::RESET_PIN_CONFIG;
      end else if (I_CE && write_to(power_event_pkg::ADDR_INT_PIN_CONFIG) &&
                   key_open) begin                                              // RULE2
         int_pin_config <= I_SFR_WDATA & power_event_pkg::PIN_CONFIG_MASK;
      end
   end

   // Power control register
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         power_control <= power_event_pkg::RESET_POWER_CONTROL;
      end else if (I_CE && write_to(power_event_pkg::ADDR_POWER_CONTROL)) begin
         power_control <= I_SFR_WDATA;                                          // RULE12
      end
   end

   // Switchover configuration register
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         switchover_config <= power_event_pkg::RESET_SWITCHOVER;
      end else if (I_CE && write_to(power_event_pkg::ADDR_SWITCHOVER_CONFIG)) begin
         switchover_config <= I_SFR_WDATA;                                      // RULE12
      end
   end

   // Peripheral configuration register
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         peripheral_config <= power_event_pkg::RESET_PERIPHERAL;
      end else if (I_CE && write_to(power_event_pkg::ADDR_PERIPHERAL_CONFIG)) begin
         peripheral_config <= I_SFR_WDATA;                                      // RULE12
      end
   end

   // Scratch bytes at consecutive addresses
   genvar g;
   generate
      for (g = 0; g < power_event_pkg::SCRATCH_COUNT; g++) begin : g_scratch
         localparam logic [7:0] ADDR = power_event_pkg::ADDR_SCRATCH_ONE + 8'(g);
         always_ff @(posedge I_REF_CLK or posedge I_RST) begin
            if (I_RST) begin
               scratch[g] <= power_event_pkg::RESET_SCRATCH;
            end else if (I_CE && write_to(ADDR)) begin
               scratch[g] <= I_SFR_WDATA;                                       // RULE12
            end
         end
      end
   endgenerate

   // Read multiplexer
   always_comb begin
      read_value = power_event_pkg::READ_UNMAPPED;
      case (I_SFR_ADDR)
         power_event_pkg::ADDR_POWER_CONTROL:      read_value = power_control;
         power_event_pkg::ADDR_WRITE_KEY:          read_value = write_key_reg;
         power_event_pkg::ADDR_POWER_EVENT_ENABLE: read_value = power_event_enable;
         // Source bit shows the live synchronised level
         power_event_pkg::ADDR_PERIPHERAL_CONFIG: begin
            read_value = peripheral_config;
            read_value[power_event_pkg::BIT_SOURCE_IS_MAIN] = mon_sync[MON_SOURCE];
         end
         power_event_pkg::ADDR_SWITCHOVER_CONFIG:  read_value = switchover_config;
         power_event_pkg::ADDR_POWER_EVENT_FLAGS:  read_value = power_event_flags;
         power_event_pkg::ADDR_SCRATCH_ONE:        read_value = scratch[0];
         power_event_pkg::ADDR_SCRATCH_TWO:        read_value = scratch[1];
         power_event_pkg::ADDR_SCRATCH_THREE:      read_value = scratch[2];
         power_event_pkg::ADDR_SCRATCH_FOUR:       read_value = scratch[3];
         power_event_pkg::ADDR_INT_PIN_CONFIG:     read_value = int_pin_config;
         default:                                  read_value = power_event_pkg::READ_UNMAPPED;
      endcase
   end

   // Read data holds until the next read strobe
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_SFR_RDATA <= power_event_pkg::READ_UNMAPPED;
      end else if (I_CE && I_SFR_RD) begin
         O_SFR_RDATA <= read_value;                                             // RULE12
      end
   end

   // First pin enable follows its configuration bit one cycle later
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_FIRST_PIN_ENABLE <= 1'b0;
      end else if (I_CE) begin
         O_FIRST_PIN_ENABLE <= int_pin_config[power_event_pkg::BIT_FIRST_PIN_ENABLE]; // RULE1
      end
   end

   // Second pin function decode
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_SECOND_PIN_GPIO       <= 1'b1;
         O_SECOND_PIN_BACKUP     <= 1'b0;
         O_SECOND_PIN_IRQ_ENABLE <= 1'b0;
      end else if (I_CE) begin
         O_SECOND_PIN_GPIO <= field_is(int_pin_config,
            power_event_pkg::POS_SECOND_LOW_PAIR, power_event_pkg::LOW_PAIR_GPIO);      // RULE1
         O_SECOND_PIN_BACKUP <= field_is(int_pin_config,
            power_event_pkg::POS_SECOND_LOW_PAIR, power_event_pkg::LOW_PAIR_BACKUP);    // RULE1
         O_SECOND_PIN_IRQ_ENABLE <= field_is(int_pin_config,
            power_event_pkg::POS_SECOND_HIGH_PAIR, power_event_pkg::HIGH_PAIR_ENABLED); // RULE1
      end
   end

   // Outputs straight from their registers
   assign O_POWER_IRQ         = power_event_flags[power_event_pkg::BIT_COMBINED_IRQ];
   assign O_POWER_CONTROL     = power_control;
   assign O_SWITCHOVER_CONFIG = switchover_config;
   assign O_PERIPHERAL_CONFIG = peripheral_config;

endmodule : power_event_ctrl

// ==== power_event_ctrl_tb_top.sv ====
// Self-checking testbench for the power event block
`timescale 1ns/1ps
module power_event_ctrl_tb_top;
   logic       clk;
   logic       rst;
   logic       ce;
   logic [7:0] addr;
   logic       wr;
   logic [7:0] wdata;
   logic       rd;
   logic [7:0] rdata;
   logic       src;
   logic [5:0] mon;
   logic       irq;
   logic [3:0] pins;
   logic [7:0] pc;
   logic [7:0] sc;
   logic [7:0] pcfg;
   logic [7:0] got;
   logic [7:0] d;
   logic [3:0] cfg;
   logic       lock;
   logic       en_on;
   integer     seed;
   integer     bad_count;
   integer     num_checks;
   int         bitpos [8] = '{5, 3, 3, 2, 2, 0, 1, 7};
   logic [7:0] regs [10] = '{8'hc5, 8'hec, 8'hf4, 8'hf5, 8'hf8, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff};
   power_event_ctrl DUT (
      .I_REF_CLK(clk), .I_RST(rst), .I_CE(ce), .I_SFR_ADDR(addr), .I_SFR_WR(wr),
      .I_SFR_WDATA(wdata), .I_SFR_RD(rd), .O_SFR_RDATA(rdata), .I_SOURCE_IS_MAIN(src),
      .I_LINE_SAG(mon[0]), .I_DC_DELTA(mon[1]), .I_DC_READY(mon[2]), .I_BATTERY_LOW(mon[3]),
      .I_BATTERY_READY(mon[4]), .I_DC_INPUT_LOW(mon[5]), .O_POWER_IRQ(irq),
      .O_FIRST_PIN_ENABLE(pins[3]), .O_SECOND_PIN_GPIO(pins[2]), .O_SECOND_PIN_BACKUP(pins[1]),
      .O_SECOND_PIN_IRQ_ENABLE(pins[0]), .O_POWER_CONTROL(pc), .O_SWITCHOVER_CONFIG(sc),
      .O_PERIPHERAL_CONFIG(pcfg));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] act);
      num_checks++;
      if (act !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, act);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      addr = a;
      wdata = v;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
      @(posedge clk);
      #1;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      got = rdata;
      @(posedge clk);
      #1;
   endtask : rd_reg
   function automatic logic [7:0] rw_exp(input logic [7:0] a, input logic [7:0] v);
      if (a == 8'hec) return v & 8'haf;
      if (a == 8'hf4) return {v[7], src, v[5:0]};
      return v;
   endfunction : rw_exp
   function automatic logic [3:0] pin_dec(input logic [3:0] c);
      return {c[0], c[2:1] == 2'h0, c[2:1] == 2'h1, c[3:2] == 2'h3};
   endfunction : pin_dec
   function automatic logic [7:0] flag_exp(input int e, input logic on);
      return (8'h01 << bitpos[e]) | (on ? 8'h40 : 8'h00);
   endfunction : flag_exp
   task automatic end_sim;
      $display("Checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   initial begin
      #200000;
      bad_count++;
      end_sim();
   end
   initial begin
      seed = 65;
      bad_count = 0;
      num_checks = 0;
      {rst, ce, src, wr, rd} = 5'b11100;
      {addr, wdata, mon} = '0;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      foreach (regs[i]) begin
         rd_reg(regs[i]);
         chk("reset value", (regs[i] == 8'hf4) ? 8'h40 : 8'h00, got);
      end
      chk("reset pins", 8'h04, {4'h0, pins});
      $display("Test reset values finished");
      foreach (regs[i]) begin
         if (regs[i] != 8'hf8 && regs[i] != 8'hff) begin
            d = 8'($random(seed));
            wr_reg(regs[i], d);
            rd_reg(regs[i]);
            chk("read back", rw_exp(regs[i], d), got);
            if (regs[i] == 8'hc5) chk("power control out", d, pc);
            if (regs[i] == 8'hf5) chk("switchover out", d, sc);
            if (regs[i] == 8'hf4) chk("peripheral out", d, pcfg);
         end
      end
      wr_reg(8'h90, 8'hff);
      rd_reg(8'h90);
      chk("unmapped", 8'h00, got);
      wr_reg(8'hfb, 8'hc3);
      ce = 1'b0;
      wr_reg(8'hfb, 8'h3c);
      ce = 1'b1;
      rd_reg(8'hfb);
      chk("frozen write", 8'hc3, got);
      $display("Test register access finished");
      cfg = 4'h0;
      wr_reg(8'hff, 8'h0f);
      rd_reg(8'hff);
      chk("locked config", 8'h00, got);
      for (int v = 0; v < 16; v++) begin
         lock = (v % 5 == 3);
         wr_reg(8'hc1, lock ? 8'h6b : 8'hea);
         wr_reg(8'hff, 8'(v) | 8'hf0);
         wr_reg(8'hc1, 8'h00);
         if (!lock) cfg = v[3:0];
         rd_reg(8'hff);
         chk("pin config", {4'h0, cfg}, got);
         chk("pin decode", {4'h0, pin_dec(cfg)}, {4'h0, pins});
      end
      $display("Test pin configuration finished");
      for (int e = 0; e < 8; e++) begin
         en_on = (e == 0) || ($random(seed) % 2 != 0);
         wr_reg(8'hec, en_on ? 8'(1 << bitpos[e]) : 8'h00);
         if (e < 6) begin
            mon[e] = 1'b1;
            repeat (3) @(posedge clk);
            #1;
            mon[e] = 1'b0;
         end else begin
            src = (e == 7);
         end
         repeat (8) @(posedge clk);
         #1;
         rd_reg(8'hf8);
         chk("event flags", flag_exp(e, en_on), got);
         chk("power irq", {7'h0, en_on}, {7'h0, irq});
         wr_reg(8'hf8, 8'h00);
         rd_reg(8'hf8);
         chk("cleared flags", 8'h00, got);
      end
      $display("Test power events finished");
      wr_reg(8'hec, 8'h20);
      mon[0] = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      wr_reg(8'hf8, 8'h00);
      mon[0] = 1'b0;
      rd_reg(8'hf8);
      chk("set beats clear", 8'h60, got);
      $display("Test set over clear finished");
      end_sim();
   end
endmodule : power_event_ctrl_tb_top

// ==== power_event_pkg.sv ====
// Constants for the power event flag and interrupt pin configuration block
// Operation
// [RULE1] Decode pin configuration into pin functions
// [RULE2] Pin configuration writable only when key unlocked
// [RULE3] Software unlocks, writes, then relocks key
// [RULE4] Bit 7 set on battery to main
// [RULE5] Bit 6 set on any enabled event
// [RULE6] Bit 5 set on line sag
// [RULE7] Bit 3 set on DC delta or ready
// [RULE8] Bit 2 set on battery low or ready
// [RULE9] Bit 1 set on main to battery
// [RULE10] Bit 0 set on DC input low
// [RULE11] Software writes reserved bit 4 as zero
// [RULE12] All controls readable and writable registers
// [RULE13] Enable bit per flag gates combined interrupt
// [RULE14] Flags sticky; hardware set beats clear
package power_event_pkg;

   // Register addresses on the core register bus
   localparam logic [7:0] ADDR_POWER_CONTROL      = 8'hc5;
   localparam logic [7:0] ADDR_WRITE_KEY          = 8'hc1;
   localparam logic [7:0] ADDR_POWER_EVENT_ENABLE = 8'hec;
   localparam logic [7:0] ADDR_PERIPHERAL_CONFIG  = 8'hf4;
   localparam logic [7:0] ADDR_SWITCHOVER_CONFIG  = 8'hf5;
   localparam logic [7:0] ADDR_POWER_EVENT_FLAGS  = 8'hf8;
   localparam logic [7:0] ADDR_SCRATCH_ONE        = 8'hfb;
   localparam logic [7:0] ADDR_SCRATCH_TWO        = 8'hfc;
   localparam logic [7:0] ADDR_SCRATCH_THREE      = 8'hfd;
   localparam logic [7:0] ADDR_SCRATCH_FOUR       = 8'hfe;
   localparam logic [7:0] ADDR_INT_PIN_CONFIG     = 8'hff;

   // Key value that opens the pin configuration register
   localparam logic [7:0] WRITE_KEY_UNLOCK        = 8'hea;

   // Flag and enable bit positions
   localparam int BIT_SUPPLY_RESTORED = 7;
   localparam int BIT_COMBINED_IRQ    = 6;
   localparam int BIT_LINE_SAG        = 5;
   localparam int BIT_RESERVED_FLAG   = 4;
   localparam int BIT_DC_INPUT_ADC    = 3;
   localparam int BIT_BATTERY_MONITOR = 2;
   localparam int BIT_SWITCHOVER      = 1;
   localparam int BIT_DC_INPUT_LOW    = 0;

   // Writable bits of the flag and enable registers (bits 6 and 4 excluded in enable)
   localparam logic [7:0] FLAG_WRITE_MASK   = 8'hef;
   localparam logic [7:0] ENABLE_WRITE_MASK = 8'haf;
   localparam logic [7:0] EVENT_MASK        = 8'haf;

   // Pin configuration fields
   localparam int BIT_FIRST_PIN_ENABLE = 0;
   localparam int POS_SECOND_LOW_PAIR  = 1;
   localparam int POS_SECOND_HIGH_PAIR = 2;
   localparam logic [1:0] LOW_PAIR_GPIO      = 2'h0;
   localparam logic [1:0] LOW_PAIR_BACKUP    = 2'h1;
   localparam logic [1:0] HIGH_PAIR_ENABLED  = 2'h3;
   localparam logic [7:0] PIN_CONFIG_MASK    = 8'h0f;

   // Peripheral configuration: bit showing the switched output source
   localparam int BIT_SOURCE_IS_MAIN = 6;

   // Reset values
   localparam logic [7:0] RESET_POWER_CONTROL = 8'h00;
   localparam logic [7:0] RESET_ENABLE        = 8'h00;
   localparam logic [7:0] RESET_PERIPHERAL    = 8'h00;
   localparam logic [7:0] RESET_SWITCHOVER    = 8'h00;
   localparam logic [7:0] RESET_FLAGS         = 8'h00;
   localparam logic [7:0] RESET_SCRATCH       = 8'h00;
   localparam logic [7:0] RESET_PIN_CONFIG    = 8'h00;
   localparam logic [7:0] RESET_KEY           = 8'h00;
   localparam logic [7:0] READ_UNMAPPED       = 8'h00;

   // Number of scratch bytes
   localparam int SCRATCH_COUNT = 4;

endpackage : power_event_pkg
